//--- hw/eebac_ctrl.sv
`timescale 1ns/100ps
module eebac_ctrl (
    input wire logic i_sys_clk, // System clock, 250 MHz.
    input wire logic i_rst, // Asynchronous reset, active high.
    input wire logic i_io_wr, // Register write strobe.
    input wire logic i_io_rd, // Register read strobe.
    input wire logic [1:0] i_io_sel, // Register select.
    input wire logic [7:0] i_io_wdata, // Register write data.
    output logic [7:0] o_io_rdata, // Register read data.
    input wire logic i_global_int_en, // Global interrupt flag from processor flags.
    input wire logic i_self_program_enable, // Flash self-programming busy.
    input wire logic i_rc_clk, // Calibrated RC oscillator level.
    output logic o_ready_irq, // Ready interrupt request level.
    output logic o_cpu_stall, // Processor halt.
    output logic [eebac_pkg::EEBAC_ADDR_W-1:0] o_mem_addr, // Array address.
    output logic [7:0] o_mem_wdata, // Array write data.
    output logic o_mem_prog, // Array programming active.
    output logic o_mem_rd, // Array read pulse.
    input wire logic [7:0] i_mem_rdata // Array read data.
);
    import eebac_pkg::*;

    // -------------------------------------------------------------------
    // Local counter constants
    // -------------------------------------------------------------------
    localparam logic [16:0] EEBAC_RC_ZERO = 17'h0_0000;
    localparam logic [16:0] EEBAC_RC_LAST = 17'h0_0001;
    localparam logic [16:0] EEBAC_RC_STEP = 17'h0_0001;
    localparam logic [2:0] EEBAC_CNT_IDLE = 3'h0;
    localparam logic [2:0] EEBAC_CNT_LAST = 3'h1;
    localparam logic [2:0] EEBAC_CNT_STEP = 3'h1;

    logic ready_interrupt_enable_q;
    logic master_write_enable_q;
    logic [2:0] master_cnt_q;
    logic write_strobe_q;
    logic [EEBAC_ADDR_W-1:0] byte_address_q;
    logic [7:0] byte_data_q;
    logic [EEBAC_ADDR_W-1:0] prog_addr_q;
    logic [7:0] prog_data_q;
    logic [2:0] stall_q;
    logic rc_s1_q;
    logic rc_s2_q;
    logic rc_s3_q;
    // The programming engine starts from a known idle state at power-up only.
    // It is kept out of the reset on purpose, so that a write survives it.
    logic [16:0] rc_cnt_q = EEBAC_RC_ZERO;
    eebac_state_e state_q = EEBAC_IDLE;
    logic prog_busy_q = 1'b0;
    // Decoded strobes for this cycle's register access.
    logic ctrl_wr;
    logic start_write;
    logic start_read;
    logic prog_start;
    // Oscillator edge and end-of-count qualifiers for the timer.
    logic rc_edge;
    logic rc_last;
    logic busy;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // True in the cycle in which the given register is written.
    function automatic logic sel_wr(input logic [1:0] sel);
        sel_wr = i_io_wr && (i_io_sel == sel);
    endfunction : sel_wr

    // Cycle counters stop at zero, so a counter that has run out stays idle
    // until the next command loads it again.
    function automatic logic [2:0] count_down(input logic [2:0] cnt);
        if (cnt == EEBAC_CNT_IDLE) begin
            count_down = EEBAC_CNT_IDLE;
        end else begin
            count_down = cnt - EEBAC_CNT_STEP;
        end
    endfunction : count_down

    // Control byte as software sees it; the read strobe is never stored.
    function automatic logic [7:0] ctrl_byte(input logic rdy_ie, input logic master, input logic pending);
        ctrl_byte = 8'h00;
        ctrl_byte[EEBAC_BIT_RDY_IE] = rdy_ie;
        ctrl_byte[EEBAC_BIT_MASTER] = master;
        ctrl_byte[EEBAC_BIT_WRITE] = pending;
        ctrl_byte[EEBAC_BIT_READ] = 1'b0;
    endfunction : ctrl_byte

    // -------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------
    // A control write carries all command bits at once, so each one is decoded
    // from the write data in the cycle of the write, not from stored state.
    assign ctrl_wr = sel_wr(EEBAC_SEL_CONTROL);
    // Busy covers a write in flight even after a reset has cleared the strobe flop.
    assign busy = write_strobe_q || prog_busy_q;
    assign start_write = ctrl_wr && i_io_wdata[EEBAC_BIT_WRITE] && master_write_enable_q
        && !busy && !i_self_program_enable;
    assign start_read = ctrl_wr && i_io_wdata[EEBAC_BIT_READ] && !busy;
    assign prog_start = start_write && (state_q == EEBAC_IDLE);
    // Rising edge of the sampled oscillator; only the second stage feeds the third.
    assign rc_edge = rc_s2_q && !rc_s3_q;
    assign rc_last = (rc_cnt_q == EEBAC_RC_LAST);

    // -------------------------------------------------------------------
    // Control bits
    // -------------------------------------------------------------------
    // Every control write rewrites the enable, since software always writes
    // the whole control byte.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ready_interrupt_enable_q <= 1'b0;
        end else if (ctrl_wr) begin
            ready_interrupt_enable_q <= i_io_wdata[EEBAC_BIT_RDY_IE];
        end
    end

    // Master enable arms for four cycles; a fresh write of one re-arms it.
    // A start consumes the arming, so one arming can never launch two writes.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            master_write_enable_q <= 1'b0;
            master_cnt_q <= EEBAC_CNT_IDLE;
        end else if (ctrl_wr && i_io_wdata[EEBAC_BIT_MASTER] && !i_io_wdata[EEBAC_BIT_WRITE]) begin
            master_write_enable_q <= 1'b1;
            master_cnt_q <= EEBAC_MASTER_CYCLES;
        end else if (start_write || (ctrl_wr && !i_io_wdata[EEBAC_BIT_MASTER])) begin
            master_write_enable_q <= 1'b0;
            master_cnt_q <= EEBAC_CNT_IDLE;
        end else if (master_cnt_q != EEBAC_CNT_IDLE) begin
            master_cnt_q <= count_down(master_cnt_q);
            master_write_enable_q <= (master_cnt_q != EEBAC_CNT_LAST);
        end
    end

    // -------------------------------------------------------------------
    // Address and data registers
    // -------------------------------------------------------------------
    // Address has no reset: its initial value is undefined.
    // Both halves are frozen while busy, so a pending write cannot be retargeted.
    always_ff @(posedge i_sys_clk) begin
        if (sel_wr(EEBAC_SEL_ADDR_LO) && !busy) begin
            byte_address_q[7:0] <= i_io_wdata;
        end
        if (sel_wr(EEBAC_SEL_ADDR_HI) && !busy) begin
            byte_address_q[EEBAC_ADDR_W-1:8] <= i_io_wdata[EEBAC_ADDR_HI_W-1:0];
        end
    end

    // A read result and a data write never meet in one cycle, since both
    // arrive through the one register port.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            byte_data_q <= EEBAC_DATA_RESET;
        end else if (start_read) begin
            byte_data_q <= i_mem_rdata;
        end else if (sel_wr(EEBAC_SEL_DATA)) begin
            byte_data_q <= i_io_wdata;
        end
    end

    // -------------------------------------------------------------------
    // Processor stall
    // -------------------------------------------------------------------
    // The counter is loaded by the accepted command and counts down once a
    // cycle; the processor is held for as long as it is not zero.
    // A read takes precedence when one control write asks for both.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stall_q <= EEBAC_CNT_IDLE;
        end else if (start_read) begin
            stall_q <= EEBAC_READ_STALL;
        end else if (start_write) begin
            stall_q <= EEBAC_WRITE_STALL;
        end else begin
            stall_q <= count_down(stall_q);
        end
    end

    // -------------------------------------------------------------------
    // Write strobe, cleared by programming completion
    // -------------------------------------------------------------------
    // The flop itself is reset; software still sees a pending write through
    // the busy term until the engine has finished.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            write_strobe_q <= 1'b0;
        end else if (start_write) begin
            write_strobe_q <= 1'b1;
        end else if (state_q == EEBAC_COMMIT) begin
            write_strobe_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Self-timed programming on the RC oscillator
    // -------------------------------------------------------------------
    // The oscillator is sampled three times: two stages settle it, the third gives the edge.
    always_ff @(posedge i_sys_clk) begin
        rc_s1_q <= i_rc_clk;
        rc_s2_q <= rc_s1_q;
        rc_s3_q <= rc_s2_q;
    end

    // Sequencer: idle, counting oscillator edges, then one cycle to release the strobe.
    always_ff @(posedge i_sys_clk) begin
        unique case (state_q)
            EEBAC_IDLE: begin
                if (prog_start) begin
                    state_q <= EEBAC_PROG;
                end
            end
            EEBAC_PROG: begin
                if (rc_edge && rc_last) begin
                    state_q <= EEBAC_COMMIT;
                end
            end
            EEBAC_COMMIT: begin
                state_q <= EEBAC_IDLE;
            end
            default: begin
                state_q <= EEBAC_IDLE;
            end
        endcase
    end

    // Oscillator edge counter; it is loaded at the start and runs only while programming.
    always_ff @(posedge i_sys_clk) begin
        if (prog_start) begin
            rc_cnt_q <= EEBAC_PROG_RC_CYCLES;
        end else if (state_q == EEBAC_PROG && rc_edge) begin
            rc_cnt_q <= rc_cnt_q - EEBAC_RC_STEP;
        end
    end

    // Address and data are latched at the start, so later register writes cannot reach the cell.
    always_ff @(posedge i_sys_clk) begin
        if (prog_start) begin
            prog_addr_q <= byte_address_q;
            prog_data_q <= byte_data_q;
        end
    end

    // Programming stays active from the start until the sequencer leaves its commit cycle.
    always_ff @(posedge i_sys_clk) begin
        if (prog_start) begin
            prog_busy_q <= 1'b1;
        end else if (state_q == EEBAC_COMMIT) begin
            prog_busy_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Read data is forced to zero outside a read, so the shared port stays quiet.
    always_comb begin
        o_io_rdata = 8'h00;
        unique case (i_io_sel)
            EEBAC_SEL_CONTROL: o_io_rdata = ctrl_byte(ready_interrupt_enable_q, master_write_enable_q, busy);
            EEBAC_SEL_ADDR_LO: o_io_rdata = byte_address_q[7:0];
            EEBAC_SEL_ADDR_HI: o_io_rdata = {4'h0, byte_address_q[EEBAC_ADDR_W-1:8]};
            EEBAC_SEL_DATA: o_io_rdata = byte_data_q;
        endcase
        if (!i_io_rd) begin
            o_io_rdata = 8'h00;
        end
    end

    // The ready request is a level that stands for as long as both interrupt enables are set and no write is pending.
    assign o_ready_irq = ready_interrupt_enable_q && i_global_int_en && !busy;
    assign o_cpu_stall = (stall_q != EEBAC_CNT_IDLE);
    // The array sees the latched address for the whole write and the live one otherwise.
    assign o_mem_addr = prog_busy_q ? prog_addr_q : byte_address_q;
    assign o_mem_wdata = prog_data_q;
    assign o_mem_prog = prog_busy_q;
    assign o_mem_rd = start_read;
endmodule : eebac_ctrl

//--- hw/eebac_pkg.sv
package eebac_pkg;
    // -------------------------------------------------------------------
    // Register selects on the I/O port
    // -------------------------------------------------------------------
    localparam logic [1:0] EEBAC_SEL_CONTROL = 2'h0;
    localparam logic [1:0] EEBAC_SEL_ADDR_LO = 2'h1;
    localparam logic [1:0] EEBAC_SEL_ADDR_HI = 2'h2;
    localparam logic [1:0] EEBAC_SEL_DATA = 2'h3;
    // -------------------------------------------------------------------
    // Control register fields, address width and data reset value
    // -------------------------------------------------------------------
    localparam int EEBAC_BIT_READ = 0;
    localparam int EEBAC_BIT_WRITE = 1;
    localparam int EEBAC_BIT_MASTER = 2;
    localparam int EEBAC_BIT_RDY_IE = 3;
    localparam int EEBAC_ADDR_W = 12;
    localparam int EEBAC_ADDR_HI_W = EEBAC_ADDR_W - 8;
    localparam logic [7:0] EEBAC_DATA_RESET = 8'h00;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam logic [2:0] EEBAC_MASTER_CYCLES = 3'h4;
    localparam logic [2:0] EEBAC_WRITE_STALL = 3'h2;
    localparam logic [2:0] EEBAC_READ_STALL = 3'h4;
    localparam logic [16:0] EEBAC_PROG_RC_CYCLES = 17'h1_0800;
    localparam logic [2:0] EEBAC_RC_SYNC_W = 3'h2;
    typedef enum logic [1:0] {
        EEBAC_IDLE,
        EEBAC_PROG,
        EEBAC_COMMIT
    } eebac_state_e;
endpackage : eebac_pkg

//--- testbench/eebac_checker.sv
`timescale 1ns/100ps
module eebac_checker
    import eebac_pkg::*;
(
    input wire logic i_sys_clk, // Clock.
    input wire logic i_rst, // Reset.
    input wire logic i_io_wr, // Write.
    input wire logic i_io_rd, // Read.
    input wire logic [1:0] i_io_sel, // Select.
    input wire logic [7:0] i_io_wdata, // Wdata.
    input wire logic [7:0] o_io_rdata, // Rdata.
    input wire logic i_global_int_en, // Global.
    input wire logic i_self_program_enable, // Flash busy.
    input wire logic o_ready_irq, // Irq.
    input wire logic o_cpu_stall, // Stall.
    input wire logic [11:0] o_mem_addr, // Addr.
    input wire logic [7:0] o_mem_wdata, // Data.
    input wire logic o_mem_prog, // Prog.
    input wire logic o_mem_rd // Read.
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic ctl_rd;
    assign ctl_rd = i_io_rd && i_io_sel == EEBAC_SEL_CONTROL;
    AST_RSV: assert property (ctl_rd |-> o_io_rdata[7:4] == 4'h0) else $error("reserved bits set");
    AST_IRQ: assert property (ctl_rd |-> o_ready_irq == (o_io_rdata[3] && i_global_int_en && !o_io_rdata[1]))
        else $error("irq level wrong");
    AST_GLB: assert property (!i_global_int_en |-> !o_ready_irq) else $error("irq without global");
    AST_RDGO: assert property (i_io_wr && i_io_sel == EEBAC_SEL_CONTROL && i_io_wdata[0] && !o_mem_prog
        |-> o_mem_rd) else $error("read not started");
    AST_RDST: assert property (o_mem_rd |=> o_cpu_stall [*4]) else $error("read stall short");
    AST_BLK: assert property (o_mem_prog |-> !o_mem_rd) else $error("read while busy");
    AST_GO: assert property ($rose(o_mem_prog) |-> $past(i_io_wr && i_io_sel == EEBAC_SEL_CONTROL
        && i_io_wdata[1] && !i_self_program_enable)) else $error("write start cause");
    AST_WRST: assert property ($rose(o_mem_prog) |-> o_cpu_stall [*2]) else $error("write stall short");
    AST_HOLD: assert property (o_mem_prog && $past(o_mem_prog) |-> $stable(o_mem_addr) && $stable(o_mem_wdata))
        else $error("captured value moved");
    COV_RD: cover property (o_mem_rd);
    COV_WR: cover property ($fell(o_mem_prog));
    COV_IRQ: cover property (o_ready_irq);
endmodule : eebac_checker
bind eebac_ctrl eebac_checker u_chk (.i_sys_clk, .i_rst, .i_io_wr, .i_io_rd, .i_io_sel, .i_io_wdata,
    .o_io_rdata, .i_global_int_en, .i_self_program_enable, .o_ready_irq, .o_cpu_stall, .o_mem_addr,
    .o_mem_wdata, .o_mem_prog, .o_mem_rd);

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import eebac_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_io_wr = 1'b0;
    logic i_io_rd = 1'b0;
    logic [1:0] i_io_sel = 2'h0;
    logic [7:0] i_io_wdata = 8'h00;
    logic i_global_int_en = 1'b0;
    logic i_self_program_enable = 1'b0;
    logic i_rc_clk = 1'b0;
    logic rc_run = 1'b0;
    logic [7:0] o_io_rdata, o_mem_wdata, i_mem_rdata, v;
    logic [11:0] o_mem_addr;
    logic o_ready_irq, o_cpu_stall, o_mem_prog, o_mem_rd;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    // The oscillator only runs while a write is being timed.
    always @(negedge i_sys_clk) if (rc_run) i_rc_clk <= ~i_rc_clk;
    assign i_mem_rdata = o_mem_addr[7:0] + 8'h11;
    eebac_ctrl DUT (.i_sys_clk, .i_rst, .i_io_wr, .i_io_rd, .i_io_sel, .i_io_wdata, .o_io_rdata,
        .i_global_int_en, .i_self_program_enable, .i_rc_clk, .o_ready_irq, .o_cpu_stall, .o_mem_addr,
        .o_mem_wdata, .o_mem_prog, .o_mem_rd, .i_mem_rdata);
    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_io_sel = s;
        i_io_wdata = d;
        i_io_wr = 1'b1;
        @(negedge i_sys_clk);
        i_io_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        @(negedge i_sys_clk);
        i_io_sel = s;
        i_io_rd = 1'b1;
        #1 d = o_io_rdata;
        @(negedge i_sys_clk);
        i_io_rd = 1'b0;
    endtask : rd
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 150000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk) i_rst = 1'b0;
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h00, v);
        rd(EEBAC_SEL_DATA, v); chk("data", 8'h00, v);
        wr(EEBAC_SEL_ADDR_LO, 8'hA3);
        wr(EEBAC_SEL_ADDR_HI, 8'h05);
        wr(EEBAC_SEL_CONTROL, 8'hF1);
        chk("stall", 8'h01, {7'h00, o_cpu_stall});
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h00, v);
        rd(EEBAC_SEL_DATA, v); chk("rdata", 8'hB4, v);
        wr(EEBAC_SEL_CONTROL, 8'h02);
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h00, v);
        wr(EEBAC_SEL_CONTROL, 8'h04);
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h04, v);
        repeat (4) @(negedge i_sys_clk);
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h00, v);
        wr(EEBAC_SEL_CONTROL, 8'h02); chk("prog", 8'h00, {7'h00, o_mem_prog});
        i_self_program_enable = 1'b1;
        wr(EEBAC_SEL_CONTROL, 8'h04);
        wr(EEBAC_SEL_CONTROL, 8'h02); chk("prog", 8'h00, {7'h00, o_mem_prog});
        i_self_program_enable = 1'b0;
        wr(EEBAC_SEL_DATA, 8'h3C);
        wr(EEBAC_SEL_CONTROL, 8'h0C);
        wr(EEBAC_SEL_CONTROL, 8'h0E);
        i_global_int_en = 1'b1;
        rc_run = 1'b1;
        chk("prog", 8'h01, {7'h00, o_mem_prog});
        chk("stall", 8'h01, {7'h00, o_cpu_stall});
        chk("irq", 8'h00, {7'h00, o_ready_irq});
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h0A, v);
        wr(EEBAC_SEL_ADDR_LO, 8'hFF);
        wr(EEBAC_SEL_CONTROL, 8'h09);
        chk("addr", 8'hA3, o_mem_addr[7:0]);
        i_rst = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        i_rst = 1'b0;
        chk("prog", 8'h01, {7'h00, o_mem_prog});
        chk("wdata", 8'h3C, o_mem_wdata);
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h02, v);
        for (int k = 0; k < 200000 && o_mem_prog !== 1'b0; k++) @(negedge i_sys_clk);
        rc_run = 1'b0;
        chk("prog", 8'h00, {7'h00, o_mem_prog});
        rd(EEBAC_SEL_CONTROL, v); chk("ctrl", 8'h00, v);
        rd(EEBAC_SEL_ADDR_LO, v); chk("addr", 8'hA3, v);
        rd(EEBAC_SEL_DATA, v); chk("data", 8'h00, v);
        wr(EEBAC_SEL_CONTROL, 8'h08); chk("irq", 8'h01, {7'h00, o_ready_irq});
        i_global_int_en = 1'b0;
        #1 chk("irq", 8'h00, {7'h00, o_ready_irq});
        complete_run();
    end
endmodule : tb_top
